// [rtl/bsaa_pkg.sv]
package bsaa_pkg;
  // Address widths and sizes
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned SLOT_W       = 6;
  localparam int unsigned DATA_W       = 8;
  // Automatic allocation constants
  localparam logic [11:0] DISCRETE_BASE = 12'h000;
  localparam logic [11:0] ANALOG_BASE   = 12'h100;
  localparam logic [11:0] DISCRETE_SPAN = 12'h004;
  localparam logic [11:0] ANALOG_SPAN   = 12'h010;
  localparam logic [5:0]  FIRST_SLOT    = 6'h04;
  // Module limits
  localparam logic [5:0]  MAX_MODULES   = 6'h1F;
  localparam logic [3:0]  MAX_PER_ROW   = 4'h8;
  localparam logic [2:0]  MAX_ROWS      = 3'h4;
  // Image covers addresses 0..127
  localparam int unsigned IMAGE_DEPTH  = 128;
  localparam logic [11:0] IMAGE_LIMIT   = 12'h080;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;

  // Module classes reported by the backplane
  typedef enum logic [1:0] {
    BSAA_DISCRETE,
    BSAA_ANALOG,
    BSAA_FUNCTION,
    BSAA_COMM
  } bsaa_class_type;
endpackage : bsaa_pkg

// [rtl/bsaa_img_if.sv]
`timescale 1ns/10ps
// Image port between the allocator core and the image store
interface bsaa_img_if;
  import bsaa_pkg::*;
  logic              wr;
  logic [6:0]        addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  modport core  (output wr, output addr, output wdata, input rdata);
  modport store (input wr, input addr, input wdata, output rdata);
endinterface : bsaa_img_if

// [rtl/bsaa_image.sv]
`timescale 1ns/10ps
// One half of the process image: a 128 byte store
module bsaa_image #(
  parameter int unsigned DEPTH = bsaa_pkg::IMAGE_DEPTH
) (
  // Clock and reset
  input wire logic   ref_clk,
  input wire logic   rstn,
  // Access port
  bsaa_img_if.store  port
);
  import bsaa_pkg::*;

  logic [7:0] mem [DEPTH];

  // Byte store; cleared at reset so the image is defined
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= RESET_BYTE;
      end
    end else if (port.wr) begin
      mem[port.addr] <= port.wdata;
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port.rdata <= RESET_BYTE;
    end else begin
      port.rdata <= mem[port.addr];
    end
  end
endmodule : bsaa_image

// [rtl/bsaa_allocator.sv]
`timescale 1ns/10ps
module bsaa_allocator (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // Module registration from backplane scan
  input  wire logic                      reg_valid,
  input  wire logic [bsaa_pkg::SLOT_W-1:0] reg_slot,
  input  wire logic [1:0]                reg_row,
  input  wire bsaa_pkg::bsaa_class_type  reg_class,
  input  wire logic                      reg_cfg_valid,
  input  wire logic [bsaa_pkg::ADDR_W-1:0] reg_cfg_addr,
  input  wire logic                      alloc_clear,
  // Allocation result
  output logic                           alloc_done,
  output logic [bsaa_pkg::ADDR_W-1:0]    alloc_start,
  output logic [bsaa_pkg::ADDR_W-1:0]    alloc_span,
  output logic                           alloc_error,
  output logic [5:0]                     module_count,
  // Controller access
  input  wire logic                      acc_req,
  input  wire logic                      acc_write,
  input  wire logic                      acc_direct,
  input  wire logic                      acc_output,
  input  wire logic [bsaa_pkg::ADDR_W-1:0] acc_addr,
  input  wire logic [7:0]                acc_wdata,
  output logic                           acc_ack,
  output logic [7:0]                     acc_rdata,
  output logic                           acc_error,
  // Peripheral bus towards the modules
  output logic                           per_req,
  output logic                           per_write,
  output logic [bsaa_pkg::ADDR_W-1:0]    per_addr,
  output logic [7:0]                     per_wdata,
  input  wire logic                      per_ack,
  input  wire logic [7:0]                per_rdata,
  // Cycle end refresh
  input  wire logic                      cycle_end,
  output logic                           refresh_busy
);
  import bsaa_pkg::*;

  typedef enum {
    S_IDLE,
    S_IMG_RD,
    S_IMG_DONE,
    S_DIR,
    S_REF_RD,
    S_REF_WAIT,
    S_REF_WR,
    S_REF_OUT,
    S_REF_OWAIT
  } bsaa_state_type;

  bsaa_img_if in_img ();
  bsaa_img_if out_img ();

  // Input image and output image are independent stores
  bsaa_image #(.DEPTH(IMAGE_DEPTH)) u_in_img (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .port    (in_img)
  );
  bsaa_image #(.DEPTH(IMAGE_DEPTH)) u_out_img (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .port    (out_img)
  );

  bsaa_state_type state;
  logic [3:0]     row_count [4];
  logic [6:0]     ref_idx;
  logic           ref_last;
  logic [ADDR_W-1:0] slot_off;
  logic           bad_slot;
  logic           full;

  // Slot offset; slots below four are refused
  assign bad_slot = (reg_slot < FIRST_SLOT);
  assign slot_off = ADDR_W'(reg_slot - FIRST_SLOT);
  // Count limits; the last row index relies on extension modules
  assign full = (module_count >= MAX_MODULES)
             || (row_count[reg_row] >= MAX_PER_ROW);

  // Address calculation per registration
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      alloc_done  <= 1'b0;
      alloc_start <= '0;
      alloc_span  <= '0;
      alloc_error <= 1'b0;
    end else begin
      alloc_done  <= reg_valid;
      if (reg_valid) begin
        if (bad_slot || full) begin
          alloc_error <= 1'b1;
          alloc_start <= '0;
          alloc_span  <= '0;
        end else if (reg_cfg_valid) begin
          alloc_error <= 1'b0;
          alloc_start <= reg_cfg_addr;
          alloc_span  <= (reg_class == BSAA_DISCRETE) ?
                         DISCRETE_SPAN : ANALOG_SPAN;
        end else if (reg_class == BSAA_DISCRETE) begin
          alloc_error <= 1'b0;
          alloc_start <= DISCRETE_BASE + (slot_off << 2);
          alloc_span  <= DISCRETE_SPAN;
        end else begin
          alloc_error <= 1'b0;
          // Multiple of sixteen plus 256, so always even
          alloc_start <= ANALOG_BASE + (slot_off << 4);
          alloc_span  <= ANALOG_SPAN;
        end
      end
    end
  end

  // Module counters, per row and in total
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      module_count <= '0;
      for (int r = 0; r < 4; r++) begin
        row_count[r] <= '0;
      end
    end else if (alloc_clear) begin
      module_count <= '0;
      for (int r = 0; r < 4; r++) begin
        row_count[r] <= '0;
      end
    end else if (reg_valid && !bad_slot && !full) begin
      module_count     <= module_count + 6'h01;
      row_count[reg_row] <= row_count[reg_row] + 4'h1;
    end
  end

  assign ref_last = (ref_idx == 7'h7F);

  // Access and refresh sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state   <= S_IDLE;
      ref_idx <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          // Refresh has priority so the image is consistent per cycle
          if (cycle_end) begin
            ref_idx <= '0;
            state   <= S_REF_OUT;
          end else if (acc_req) begin
            if (acc_direct || acc_addr >= IMAGE_LIMIT) begin
              state <= S_DIR;
            end else begin
              state <= S_IMG_RD;
            end
          end
        end
        S_IMG_RD:   state <= S_IMG_DONE;
        S_IMG_DONE: state <= S_IDLE;
        S_DIR:      if (per_ack) state <= S_IDLE;
        S_REF_OUT:  state <= S_REF_OWAIT;
        S_REF_OWAIT: if (per_ack) begin
          // Output byte written to module, next input byte
          state <= S_REF_RD;
        end
        S_REF_RD:   if (per_ack) state <= S_REF_WR;
        S_REF_WAIT: state <= S_REF_WR;
        S_REF_WR: begin
          ref_idx <= ref_idx + 7'h01;
          state   <= ref_last ? S_IDLE : S_REF_OUT;
        end
      endcase
    end
  end

  // Latched peripheral read during refresh
  logic [7:0] ref_byte;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_byte <= RESET_BYTE;
    end else if (state == S_REF_RD && per_ack) begin
      ref_byte <= per_rdata;
    end
  end

  // Controller answer, registered
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_rdata <= RESET_BYTE;
      acc_error <= 1'b0;
    end else if (state == S_DIR && per_ack) begin
      acc_rdata <= per_rdata;
      acc_error <= 1'b0;
    end else if (state == S_IMG_DONE) begin
      acc_rdata <= acc_output ? out_img.rdata : in_img.rdata;
      acc_error <= 1'b0;
    end
  end

  assign acc_ack = (state == S_IMG_DONE) || (state == S_DIR && per_ack);
  assign refresh_busy = (state == S_REF_OUT) || (state == S_REF_OWAIT)
                     || (state == S_REF_RD) || (state == S_REF_WAIT)
                     || (state == S_REF_WR);

  // Image port steering
  always_comb begin
    in_img.addr   = (state == S_REF_WR) ? ref_idx : acc_addr[6:0];
    in_img.wr     = (state == S_REF_WR)
                 || (state == S_IMG_RD && acc_write && !acc_output);
    in_img.wdata  = (state == S_REF_WR) ? ref_byte : acc_wdata;
    out_img.addr  = refresh_busy ? ref_idx : acc_addr[6:0];
    out_img.wr    = (state == S_IMG_RD && acc_write && acc_output);
    out_img.wdata = acc_wdata;
  end

  // Peripheral bus: direct access or refresh traffic
  always_comb begin
    per_req   = (state == S_DIR) || (state == S_REF_OWAIT)
             || (state == S_REF_RD);
    per_write = (state == S_DIR) ? acc_write : (state == S_REF_OWAIT);
    per_addr  = (state == S_DIR) ? acc_addr : ADDR_W'(ref_idx);
    per_wdata = (state == S_DIR) ? acc_wdata : out_img.rdata;
  end
endmodule : bsaa_allocator

// [verification/bsaa_asserts.sv]
`timescale 1ns/10ps
// Watches the allocation result and the refresh/access handshake
module bsaa_asserts (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rstn,
  // Registration
  input wire logic                     reg_valid,
  input wire logic [5:0]               reg_slot,
  input wire bsaa_pkg::bsaa_class_type reg_class,
  input wire logic                     reg_cfg_valid,
  input wire logic [11:0]              reg_cfg_addr,
  // Result
  input wire logic                     alloc_done,
  input wire logic [11:0]              alloc_start,
  input wire logic [11:0]              alloc_span,
  input wire logic                     alloc_error,
  input wire logic [5:0]               module_count,
  // Access and refresh
  input wire logic                     acc_ack,
  input wire logic                     refresh_busy
);
  import bsaa_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Slot based placement; limit errors still allowed, so checked elsewhere
  logic auto_req;
  logic disc;
  assign auto_req = reg_valid && !reg_cfg_valid && reg_slot >= 6'h04;
  assign disc     = reg_class == BSAA_DISCRETE;
  a_done_latency: assert property (reg_valid |=> alloc_done)
    else $error("no done one cycle after registration");
  a_done_cause: assert property (alloc_done |-> $past(reg_valid))
    else $error("done without registration");
  a_disc_start: assert property (auto_req && disc |=> alloc_error ||
    alloc_start == 4 * ($past(reg_slot) - 4)) else $error("bad start");
  a_disc_span: assert property (auto_req && disc |=>
    alloc_error || alloc_span == 12'h004) else $error("bad span");
  a_wide_start: assert property (auto_req && !disc |=>
    alloc_error || alloc_start == 16 * ($past(reg_slot) - 4) + 256)
    else $error("bad start");
  a_wide_span: assert property (auto_req && !disc |=>
    alloc_error || alloc_span == 12'h010) else $error("bad span");
  a_low_slot: assert property (reg_valid && reg_slot < 6'h04 |=>
    alloc_error && alloc_start == 12'h000) else $error("low slot taken");
  a_cfg_wins: assert property (reg_valid && reg_cfg_valid &&
    reg_slot >= 6'h04 |=> alloc_error || alloc_start == $past(reg_cfg_addr))
    else $error("configured address lost");
  a_count_cap: assert property (module_count <= 6'h1F)
    else $error("module count over limit");
  a_busy_noack: assert property (refresh_busy |-> !acc_ack)
    else $error("access served during refresh");
  c_comm: cover property (reg_valid && reg_class == BSAA_COMM);
  c_err: cover property (alloc_done && alloc_error);
  c_refresh: cover property ($fell(refresh_busy));
endmodule : bsaa_asserts

// [verification/bsaa_periph.sv]
`timescale 1ns/10ps
// Backplane modules seen as one byte store behind the peripheral bus
module bsaa_periph (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        slow,
  // Peripheral bus
  input wire logic        per_req,
  input wire logic        per_write,
  input wire logic [11:0] per_addr,
  input wire logic [7:0]  per_wdata,
  output logic            per_ack,
  output logic [7:0]      per_rdata
);
  logic [7:0] mem [0:4095];
  logic [1:0] wait_cnt;
  // Ack after a short or long wait; data inverts when not valid
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      per_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      per_rdata <= 8'h00;
      for (int i = 0; i < 4096; i++) mem[i] <= 8'hA5;
    end else if (per_req && !per_ack
                 && wait_cnt == (slow ? 2'h3 : 2'h0)) begin
      per_ack   <= 1'b1;
      per_rdata <= mem[per_addr];
      wait_cnt  <= 2'h0;
    end else begin
      per_ack   <= 1'b0;
      per_rdata <= ~per_rdata;
      wait_cnt  <= per_req && !per_ack ? wait_cnt + 2'h1 : 2'h0;
      // Write lands at the edge that closes the ack cycle
      if (per_req && per_ack && per_write) begin
        mem[per_addr] <= per_wdata;
      end
    end
  end
endmodule : bsaa_periph

// [verification/bsaa_allocator_tb.sv]
`timescale 1ns/10ps
module bsaa_allocator_tb;
  import bsaa_pkg::*;
  logic ref_clk = 0, rstn = 0, slow = 0;
  logic reg_valid = 0, reg_cfg_valid = 0, alloc_clear = 0, cycle_end = 0;
  logic [5:0] reg_slot = 0, module_count;
  logic [1:0] reg_row = 0;
  bsaa_class_type reg_class = BSAA_DISCRETE;
  logic [11:0] reg_cfg_addr = 0, acc_addr = 0, alloc_start, alloc_span;
  logic acc_req = 0, acc_write = 0, acc_direct = 0, acc_output = 0;
  logic [7:0] acc_wdata = 0, acc_rdata, per_wdata, per_rdata, rd;
  logic alloc_done, alloc_error, acc_ack, acc_error, per_req, per_write;
  logic per_ack, refresh_busy;
  logic [11:0] per_addr;
  int bad_count = 0, samples_checked = 0;
  bsaa_allocator DUT (.*);
  bsaa_periph u_per (.*);
  initial forever #10 ref_clk = ~ref_clk;
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick; @(posedge ref_clk); #1; endtask : tick
  // One registration; alloc_done stands only in the cycle after the edge, start, span and error hold
  task automatic enrol(input int s, r, c, cfg, ca, st, sp, er);
    reg_valid = 1; reg_slot = 6'(s); reg_row = 2'(r);
    reg_class = bsaa_class_type'(c); reg_cfg_valid = cfg != 0;
    reg_cfg_addr = 12'(ca); tick(); reg_valid = 0;
    check(alloc_done, 12'h001);
    check(alloc_start, 12'(st));
    check(alloc_span, 12'(sp));
    check(alloc_error, 12'(er));
    tick();
    check(alloc_done, 12'h000);
  endtask : enrol
  // Holds the request through the ack edge; a free cycle follows so the
  // next call never raises the request in the step that dropped it
  task automatic access(input logic w, d, o, input int a,
                        input logic [7:0] wd);
    acc_req = 1; acc_write = w; acc_direct = d; acc_output = o;
    acc_addr = 12'(a); acc_wdata = wd;
    for (int i = 0; i <= 200; i++) begin
      if (i == 200) begin bad_count++; give_verdict(); end
      if (acc_ack === 1'b1) break;
      tick();
    end
    tick(); acc_req = 0; rd = acc_rdata;
    tick();
  endtask : access
  task automatic sc_auto;
    enrol(4, 0, 0, 0, 0, 12'h000, 4, 0);
    enrol(11, 0, 0, 0, 0, 12'h01C, 4, 0);
    // Analog, function and communication classes, one slot apart
    for (int c = 1; c < 4; c++) begin
      enrol(4 + c, 0, c, 0, 0, 16*c + 256, 16, 0);
    end
    enrol(5, 0, 1, 1, 12'h3A0, 12'h3A0, 16, 0);
    enrol(3, 0, 0, 0, 0, 0, 0, 1);
    check(module_count, 12'h006);
  endtask : sc_auto
  // Rows 0..3: first rail plus three extension rails
  task automatic sc_limits;
    int  rw;
    int  sl;
    bit  ok;
    alloc_clear = 1; tick(); alloc_clear = 0;
    // Row 1 takes eight modules, the ninth is refused
    for (int k = 0; k < 9; k++) begin
      ok = k < 8;
      enrol(4 + k, 1, 0, 0, 0, ok ? 4 * k : 0, ok ? 4 : 0, !ok);
    end
    // Remaining rows fill up to the total limit
    for (int n = 8; n < 32; n++) begin
      ok = n < 31;
      sl = n % 8;
      rw = (n / 8 == 1) ? 0 : n / 8;
      enrol(4 + sl, rw, 0, 0, 0, ok ? 4 * sl : 0, ok ? 4 : 0, !ok);
    end
    check(module_count, 12'h01F);
  endtask : sc_limits
  task automatic sc_image;
    // Fast partner first, then the slow one
    access(1, 1, 0, 12'h300, 8'hC3); access(0, 1, 0, 12'h300, 8'h00);
    check(rd, 8'hC3);
    slow = 1;
    access(1, 0, 1, 5, 8'h3C); access(0, 0, 0, 5, 8'h00);
    check(rd, 8'h00);
    access(0, 0, 1, 5, 8'h00); check(rd, 8'h3C);
    access(1, 1, 0, 12'h200, 8'h5A); access(0, 1, 0, 12'h200, 8'h00);
    check(rd, 8'h5A);
    // Image path above the image range falls through to the bus
    access(0, 0, 0, 12'h200, 8'h00); check(rd, 8'h5A);
    cycle_end = 1; tick(); cycle_end = 0;
    for (int i = 0; refresh_busy === 1'b1; i++) begin
      if (i == 5000) begin bad_count++; give_verdict(); end
      tick();
    end
    access(0, 0, 0, 5, 8'h00); check(rd, 8'h3C);
    access(0, 1, 0, 5, 8'h00); check(rd, 8'h3C);
    check(acc_error, 12'h000);
  endtask : sc_image
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1; tick();
    sc_auto(); sc_limits(); sc_image();
    give_verdict();
  end
endmodule : bsaa_allocator_tb
bind bsaa_allocator bsaa_asserts u_chk (.ref_clk, .rstn, .reg_valid,
  .reg_slot, .reg_class, .reg_cfg_valid, .reg_cfg_addr, .alloc_done,
  .alloc_start, .alloc_span, .alloc_error, .module_count, .acc_ack,
  .refresh_busy);
